// File: rtl/two_wire_ctrl.sv
// Two-wire bus controller: master sequencer, slave address matcher, Wishbone slave.
// Assumes open-drain pads outside; pins arrive from other domains, chipIdle from the ref_clk domain.
`timescale 1ns/1ps
`include "two_wire_regs.svh"

module two_wire_ctrl
   import two_wire_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   input wire logic chipIdle,
   input wire logic sclIn,
   input wire logic sdaIn,
   output pinDrv_t pins,
   output logic portOwn
);

   st_t st_r;
   st_t st_nxt;
   logic [2:0] idx;
   logic wrAck;
   logic rdAck;
   logic on;
   logic halted;
   logic mBusy;
   logic tick;
   logic sclH;
   logic sdaV;
   logic sclRise;
   logic sclFall;
   logic startC;
   logic stopC;
   logic [7:0] b;
   logic rsv;
   logic gcHit;
   logic hi10;
   logic m7;
   logic adrHit;
   logic lowHit;
   logic [15:0] ctlW;
   logic [15:0] statW;
   logic [31:0] rdMux;
   logic sdaBit;

   function automatic logic maskEq(input logic [9:0] a, input logic [9:0] o, input logic [9:0] m);
      maskEq = ((a ^ o) & ~m) == 10'h000;
   endfunction

   function automatic logic reserved7(input logic [6:0] a);
      reserved7 = (a[6:3] == `TW_RSV_LO) || (a[6:2] == `TW_RSV_HI) || (a[6:2] == `TW_UPPER10);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign idx = adr_i[4:2];
   assign wrAck = cyc_i & stb_i & st_r.ack & we_i;
   assign rdAck = cyc_i & stb_i & st_r.ack & ~we_i;
   assign on = st_r.ctl[`TW_ON];
   assign halted = st_r.ctl[`TW_HALT] & chipIdle;
   assign mBusy = st_r.mst != M_IDLE;
   assign tick = mBusy && (st_r.baud == 16'h0000);
   // Only the second synchroniser stage and its delayed copy feed logic
   assign sclH = st_r.sclSy[1];
   assign sdaV = st_r.sdaSy[1];
   assign sclRise = st_r.sclSy[1] & ~st_r.sclSy[2];
   assign sclFall = ~st_r.sclSy[1] & st_r.sclSy[2];
   assign startC = sclH & st_r.sclSy[2] & ~sdaV & st_r.sdaSy[2];
   assign stopC = sclH & st_r.sclSy[2] & sdaV & ~st_r.sdaSy[2];
   assign b = {st_r.sShf[6:0], sdaV};

   assign rsv = reserved7(b[7:1]);
   assign gcHit = (b[7:1] == 7'h00) & ~b[0] & st_r.ctl[`TW_GENERAL_CALL_ENABLE];
   assign hi10 = st_r.ctl[`TW_TEN] & (b[7:3] == `TW_UPPER10) &
                 maskEq({8'h00, b[2:1]}, {8'h00, st_r.own[9:8]}, {8'h00, st_r.msk[9:8]});
   assign m7 = ~st_r.ctl[`TW_TEN] & ~rsv &
               maskEq({3'h0, b[7:1]}, {3'h0, st_r.own[6:0]}, {3'h0, st_r.msk[6:0]});
   // Read of a 10-bit slave only after a matched low byte and a restart
   assign adrHit = st_r.ctl[`TW_ALL] | gcHit | m7 | (hi10 & (~b[0] | st_r.hiOk));
   assign lowHit = st_r.ctl[`TW_ALL] |
                   maskEq({2'h0, b}, {2'h0, st_r.own[7:0]}, {2'h0, st_r.msk[7:0]});

   always_comb begin
      ctlW = merge16(st_r.ctl, dat_i[15:0], sel_i[1:0]) & `TW_CTL_WMASK;
      if (!st_r.ctl[`TW_STRETCH_ENABLE]) begin
         ctlW[`TW_REL] = ctlW[`TW_REL] | st_r.ctl[`TW_REL];
      end
   end

   assign statW = {st_r.ackRx, st_r.trstat, 3'h0, 1'b0, st_r.gcstat, st_r.add10, st_r.wcol,
                   st_r.ov, st_r.dA, st_r.pDet, st_r.sDet, st_r.rw, st_r.rbf, st_r.tbf};

   always_comb begin
      case (idx)
         `TW_IDX_CTL: rdMux = {16'h0000, st_r.ctl};
         `TW_IDX_STAT: rdMux = {16'h0000, statW};
         `TW_IDX_BAUD: rdMux = {16'h0000, st_r.brg};
         `TW_IDX_OWN: rdMux = {22'h000000, st_r.own};
         `TW_IDX_MASK: rdMux = {22'h000000, st_r.msk};
         `TW_IDX_TXH: rdMux = {24'h000000, st_r.txd};
         `TW_IDX_RXD: rdMux = {24'h000000, st_r.rxd};
         default: rdMux = 32'h00000000;
      endcase
   end

   always_comb begin
      case (st_r.mst)
         M_TX: sdaBit = (st_r.bitCnt == 4'h8) ? 1'b0 : ~st_r.shf[7];
         M_ACK: sdaBit = ~st_r.ctl[`TW_ACKV];
         default: sdaBit = 1'b0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.sclSy = {st_r.sclSy[1:0], sclIn};
      st_nxt.sdaSy = {st_r.sdaSy[1:0], sdaIn};
      // One wait state, then ack drops for a cycle
      st_nxt.ack = cyc_i & stb_i & ~st_r.ack;
      if (cyc_i && stb_i && !st_r.ack) begin
         st_nxt.rdat = rdMux;
      end

      if (wrAck) begin
         case (idx)
            `TW_IDX_CTL: st_nxt.ctl = ctlW;
            `TW_IDX_STAT: begin
               if (sel_i[0]) begin
                  st_nxt.wcol = st_r.wcol & ~dat_i[`TW_ST_WCOL];
                  st_nxt.ov = st_r.ov & ~dat_i[`TW_ST_OV];
               end
            end
            `TW_IDX_BAUD: st_nxt.brg = merge16(st_r.brg, dat_i[15:0], sel_i[1:0]);
            `TW_IDX_OWN: st_nxt.own = 10'(merge16({6'h00, st_r.own}, dat_i[15:0], sel_i[1:0]));
            `TW_IDX_MASK: st_nxt.msk = 10'(merge16({6'h00, st_r.msk}, dat_i[15:0], sel_i[1:0]));
            `TW_IDX_TXH: begin
               if (mBusy || st_r.tbf) begin
                  st_nxt.wcol = 1'b1;
               end else if (sel_i[0]) begin
                  st_nxt.txd = dat_i[7:0];
                  st_nxt.tbf = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (rdAck && idx == `TW_IDX_RXD) begin
         st_nxt.rbf = 1'b0;
      end

      if (!on) begin
         // Pins back to port logic, sequencers parked
         st_nxt.mst = M_IDLE;
         st_nxt.slv = S_IDLE;
         st_nxt.mSclLo = 1'b0;
         st_nxt.mSdaLo = 1'b0;
         st_nxt.sSdaLo = 1'b0;
      end else if (!halted) begin
         if (!mBusy) begin
            st_nxt.baud = st_r.brg;
            st_nxt.step = 2'h0;
            st_nxt.bitCnt = 4'h0;
            if (st_r.ctl[`TW_START]) begin
               st_nxt.mst = M_START;
            end else if (st_r.ctl[`TW_RSTRT]) begin
               st_nxt.mst = M_RSTART;
            end else if (st_r.ctl[`TW_STOP]) begin
               st_nxt.mst = M_STOP;
            end else if (st_r.ctl[`TW_RCV]) begin
               st_nxt.mst = M_RX;
            end else if (st_r.ctl[`TW_ACKGO]) begin
               st_nxt.mst = M_ACK;
            end else if (st_r.tbf && st_r.slv != S_TX) begin
               // Own start puts the slave side into address watch, so only slave transmit blocks
               st_nxt.mst = M_TX;
               st_nxt.shf = st_r.txd;
               st_nxt.trstat = 1'b1;
            end
         end else begin
            st_nxt.baud = (st_r.baud == 16'h0000) ? st_r.brg : st_r.baud - 16'h0001;
         end

         if (tick) begin
            st_nxt.step = st_r.step + 2'h1;
            case (st_r.mst)
               M_START: begin
                  if (st_r.step == 2'h0) begin
                     st_nxt.mSdaLo = 1'b1;
                  end else begin
                     st_nxt.mSclLo = 1'b1;
                     st_nxt.ctl[`TW_START] = 1'b0;
                     st_nxt.mst = M_IDLE;
                  end
               end
               M_RSTART: begin
                  case (st_r.step)
                     2'h0: st_nxt.mSdaLo = 1'b0;
                     2'h1: st_nxt.mSclLo = 1'b0;
                     2'h2: st_nxt.mSdaLo = 1'b1;
                     default: begin
                        st_nxt.mSclLo = 1'b1;
                        st_nxt.ctl[`TW_RSTRT] = 1'b0;
                        st_nxt.mst = M_IDLE;
                     end
                  endcase
               end
               M_STOP: begin
                  case (st_r.step)
                     2'h0: st_nxt.mSdaLo = 1'b1;
                     2'h1: st_nxt.mSclLo = 1'b0;
                     default: begin
                        st_nxt.mSdaLo = 1'b0;
                        st_nxt.ctl[`TW_STOP] = 1'b0;
                        st_nxt.mst = M_IDLE;
                     end
                  endcase
               end
               M_TX, M_RX, M_ACK: begin
                  // Three phases per bit: set data, raise clock, sample and lower
                  case (st_r.step)
                     2'h0: st_nxt.mSdaLo = sdaBit;
                     2'h1: st_nxt.mSclLo = 1'b0;
                     default: begin
                        st_nxt.mSclLo = 1'b1;
                        st_nxt.step = 2'h0;
                        st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                        if (st_r.mst == M_TX) begin
                           st_nxt.shf = {st_r.shf[6:0], 1'b0};
                           if (st_r.bitCnt == 4'h8) begin
                              st_nxt.ackRx = sdaV;
                              st_nxt.trstat = 1'b0;
                              st_nxt.tbf = 1'b0;
                              st_nxt.mst = M_IDLE;
                           end
                        end else if (st_r.mst == M_RX) begin
                           st_nxt.shf = {st_r.shf[6:0], sdaV};
                           if (st_r.bitCnt == 4'h7) begin
                              st_nxt.rxd = {st_r.shf[6:0], sdaV};
                              // Keep a same-cycle software clear unless a new overflow occurs
                              st_nxt.ov = st_nxt.ov | st_r.rbf;
                              st_nxt.rbf = 1'b1;
                              st_nxt.ctl[`TW_RCV] = 1'b0;
                              st_nxt.mst = M_IDLE;
                           end
                        end else begin
                           st_nxt.mSdaLo = 1'b0;
                           st_nxt.ctl[`TW_ACKGO] = 1'b0;
                           st_nxt.mst = M_IDLE;
                        end
                     end
                  endcase
               end
               default: st_nxt.mst = M_IDLE;
            endcase
         end

         if (stopC) begin
            st_nxt.slv = S_IDLE;
            st_nxt.sSdaLo = 1'b0;
            st_nxt.pDet = 1'b1;
            st_nxt.sDet = 1'b0;
            st_nxt.gcstat = 1'b0;
            st_nxt.add10 = 1'b0;
            st_nxt.hiOk = 1'b0;
            st_nxt.lowPend = 1'b0;
         end else if (startC) begin
            st_nxt.slv = S_ADDR;
            st_nxt.sBit = 4'h0;
            st_nxt.sSdaLo = 1'b0;
            st_nxt.sDet = 1'b1;
            st_nxt.pDet = 1'b0;
         end else begin
            case (st_r.slv)
               S_ADDR, S_RX: begin
                  if (sclRise) begin
                     st_nxt.sShf = b;
                     st_nxt.sBit = st_r.sBit + 4'h1;
                     if (st_r.sBit == 4'h7) begin
                        st_nxt.slv = S_AACK;
                        if (st_r.slv == S_RX) begin
                           st_nxt.rxd = b;
                           st_nxt.ov = st_nxt.ov | st_r.rbf;
                           st_nxt.rbf = 1'b1;
                           st_nxt.dA = 1'b1;
                           st_nxt.sMatch = 1'b1;
                           if (st_r.ctl[`TW_STRETCH_ENABLE]) begin
                              st_nxt.ctl[`TW_REL] = 1'b0;
                           end
                        end else if (st_r.lowPend) begin
                           st_nxt.sMatch = lowHit;
                           st_nxt.add10 = lowHit;
                           st_nxt.hiOk = lowHit;
                           st_nxt.lowPend = 1'b0;
                           st_nxt.dA = 1'b0;
                        end else begin
                           st_nxt.sMatch = adrHit;
                           st_nxt.rw = b[0];
                           st_nxt.dA = 1'b0;
                           st_nxt.gcstat = st_r.gcstat | gcHit;
                           st_nxt.lowPend = hi10 & ~b[0] & ~st_r.ctl[`TW_ALL];
                        end
                     end
                  end
               end
               S_AACK: begin
                  if (sclFall) begin
                     if (st_r.sBit == 4'h8) begin
                        st_nxt.sSdaLo = st_r.sMatch;
                        st_nxt.sBit = 4'h9;
                        if (!st_r.sMatch) begin
                           st_nxt.slv = S_IDLE;
                        end
                     end else begin
                        st_nxt.sSdaLo = 1'b0;
                        st_nxt.sBit = 4'h0;
                        if (st_r.rw) begin
                           st_nxt.slv = S_TX;
                           st_nxt.ctl[`TW_REL] = 1'b0;
                        end else if (st_r.lowPend) begin
                           st_nxt.slv = S_ADDR;
                        end else begin
                           st_nxt.slv = S_RX;
                        end
                     end
                  end
               end
               S_TX: begin
                  if (st_r.sBit == 4'h0 && !st_r.ctl[`TW_REL]) begin
                     // Stretched: first bit follows the holding register
                     st_nxt.sShf = st_r.txd;
                     st_nxt.sSdaLo = ~st_r.txd[7];
                  end else if (sclFall && st_r.sBit < 4'h7) begin
                     st_nxt.sShf = {st_r.sShf[6:0], 1'b0};
                     st_nxt.sSdaLo = ~st_r.sShf[6];
                     st_nxt.sBit = st_r.sBit + 4'h1;
                  end else if (sclFall && st_r.sBit == 4'h7) begin
                     st_nxt.sSdaLo = 1'b0;
                     st_nxt.sBit = 4'h8;
                  end else if (sclRise && st_r.sBit == 4'h8) begin
                     st_nxt.tbf = 1'b0;
                     st_nxt.dA = 1'b1;
                     st_nxt.sBit = 4'h9;
                     if (sdaV) begin
                        st_nxt.slv = S_IDLE;
                     end
                  end else if (sclFall && st_r.sBit == 4'h9) begin
                     st_nxt.sBit = 4'h0;
                     st_nxt.ctl[`TW_REL] = 1'b0;
                  end
               end
               default: st_nxt.slv = S_IDLE;
            endcase
         end
      end

      // Hold only once the line is low, never chop a high phase
      st_nxt.sclDrv = st_nxt.ctl[`TW_ON] & (st_nxt.mSclLo |
                      ((st_nxt.slv == S_TX || st_nxt.slv == S_RX) & ~st_nxt.ctl[`TW_REL] &
                       (~sclH | st_r.sclDrv)));
      st_nxt.sdaDrv = st_nxt.ctl[`TW_ON] & (st_nxt.mSdaLo | st_nxt.sSdaLo);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.ctl <= `TW_CTL_RST;
         st_r.sclSy <= 3'h7;
         st_r.sdaSy <= 3'h7;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ack_o = st_r.ack;
   assign dat_o = st_r.rdat;
   assign portOwn = st_r.ctl[`TW_ON];
   assign pins.sclOut = 1'b0;
   assign pins.sclOe = st_r.sclDrv;
   assign pins.sdaOut = 1'b0;
   assign pins.sdaOe = st_r.sdaDrv;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   wb_ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("bus ack held longer than one cycle");
   pins_off_a: assert property (!on |=> !pins.sclOe && !pins.sdaOe)
      else $error("pins driven while module off");
   halt_freeze_a: assert property (on && halted |=> $stable(st_r.mst) && $stable(st_r.slv))
      else $error("sequencer moved while halted in idle");
   baud_reload_a: assert property (on && !halted && tick |=> st_r.baud == $past(st_r.brg))
      else $error("baud counter did not reload at underflow");
   stop_done_a: assert property (on && !halted && tick && st_r.mst == M_STOP && st_r.step == 2'h2
      |=> !st_r.ctl[`TW_STOP] && st_r.mst == M_IDLE && !pins.sdaOe)
      else $error("stop sequence did not finish and clear");
   rx_done_a: assert property (on && !halted && tick && st_r.mst == M_RX && st_r.step == 2'h2
      && st_r.bitCnt == 4'h7 |=> !st_r.ctl[`TW_RCV] && st_r.rbf)
      else $error("receive go not cleared after eighth bit");
   rsv_nomatch_a: assert property (on && !halted && !startC && !stopC && st_r.slv == S_ADDR
      && sclRise && st_r.sBit == 4'h7 && !st_r.lowPend && rsv && !st_r.ctl[`TW_ALL]
      && b != 8'h00 && !(hi10 && st_r.ctl[`TW_TEN]) |=> !st_r.sMatch)
      else $error("reserved address matched");
   gc_off_a: assert property (on && !halted && !startC && !stopC && st_r.slv == S_ADDR
      && sclRise && st_r.sBit == 4'h7 && !st_r.lowPend && b == 8'h00
      && !st_r.ctl[`TW_GENERAL_CALL_ENABLE] && !st_r.ctl[`TW_ALL] |=> !st_r.sMatch ##1 !(st_r.sSdaLo && sclFall))
      else $error("general call acknowledged while disabled");
   tx_release_a: assert property (on && !halted && !startC && !stopC && st_r.slv == S_AACK
      && sclFall && st_r.sBit == 4'h9 && st_r.rw |=> !st_r.ctl[`TW_REL] ##1 pins.sclOe || sclH)
      else $error("clock release not cleared at slave transmit start");
   wcol_set_a: assert property (wrAck && idx == `TW_IDX_TXH && (mBusy || st_r.tbf)
      |=> st_r.wcol && $stable(st_r.txd))
      else $error("busy transmit write not refused");

   start_seen_c: cover property (st_r.mst == M_START ##[1:300] !st_r.ctl[`TW_START]);
   addr_match_c: cover property (st_r.slv == S_AACK && st_r.sMatch && st_r.sSdaLo);
   rx_byte_c: cover property (st_r.mst == M_RX ##[1:1000] st_r.rbf);
   slave_tx_c: cover property (st_r.slv == S_TX && st_r.sBit == 4'h9);

endmodule // two_wire_ctrl

// File: rtl/two_wire_regs.svh
// Register map, field positions and reset values of the two-wire controller.
// Assumes byte addressing on a 32-bit Wishbone bus, one register per word.
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH

// Word index, byte address is four times it
`define TW_IDX_CTL 3'h0
`define TW_IDX_STAT 3'h1
`define TW_IDX_BAUD 3'h2
`define TW_IDX_OWN 3'h3
`define TW_IDX_MASK 3'h4
`define TW_IDX_TXH 3'h5
`define TW_IDX_RXD 3'h6

`define TW_CTL_RST 16'h1000
`define TW_CTL_WMASK 16'hbfff

// bus_control fields
`define TW_ON 15
`define TW_HALT 13
`define TW_REL 12
`define TW_ALL 11
`define TW_TEN 10
`define TW_GENERAL_CALL_ENABLE 7
`define TW_STRETCH_ENABLE 6
`define TW_ACKV 5
`define TW_ACKGO 4
`define TW_RCV 3
`define TW_STOP 2
`define TW_RSTRT 1
`define TW_START 0

// Status write-one-to-clear fields
`define TW_ST_WCOL 7
`define TW_ST_OV 6

// Address patterns
`define TW_RSV_LO 4'h0
`define TW_RSV_HI 5'h1f
`define TW_UPPER10 5'h1e

`endif

// File: rtl/two_wire_pkg.sv
// Types of the two-wire controller: state encodings, pin drive and state record.
// Assumes the register header supplies all numeric constants.
package two_wire_pkg;

   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_START = 3'h1,
      M_RSTART = 3'h3,
      M_TX = 3'h2,
      M_RX = 3'h6,
      M_ACK = 3'h7,
      M_STOP = 3'h5
   } mst_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_AACK = 3'h3,
      S_RX = 3'h2,
      S_TX = 3'h6
   } slv_t;

   // Open drain: out is always low, oe high pulls the line down
   typedef struct packed {
      logic sclOut;
      logic sclOe;
      logic sdaOut;
      logic sdaOe;
   } pinDrv_t;

   typedef struct packed {
      logic [15:0] ctl;
      logic [15:0] brg;
      logic [9:0] own;
      logic [9:0] msk;
      logic [7:0] txd;
      logic [7:0] rxd;
      logic ackRx;
      logic trstat;
      logic wcol;
      logic ov;
      logic rbf;
      logic tbf;
      logic gcstat;
      logic add10;
      logic dA;
      logic rw;
      logic pDet;
      logic sDet;
      logic [15:0] baud;
      mst_t mst;
      logic [1:0] step;
      logic [3:0] bitCnt;
      logic [7:0] shf;
      logic mSclLo;
      logic mSdaLo;
      slv_t slv;
      logic [3:0] sBit;
      logic [7:0] sShf;
      logic sSdaLo;
      logic sMatch;
      logic lowPend;
      logic hiOk;
      logic [2:0] sclSy;
      logic [2:0] sdaSy;
      logic sclDrv;
      logic sdaDrv;
      logic ack;
      logic [31:0] rdat;
   } st_t;

endpackage

// File: test/tw_slave_model.sv
// Bus peripheral that acknowledges bytes after a start.
// Assumes wired-AND lines with pull-ups formed by the bench.
`timescale 1ns/1ps

module tw_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ackOn,
   output logic sdaLo
);
   int cnt = 0;
   initial sdaLo = 1'b0;
   always @(negedge sda) begin
      if (scl) begin
         cnt = 0;
      end
   end
   always @(posedge scl) cnt++;
   // Pull data low from the eighth fall to the ninth
   always @(negedge scl) sdaLo <= ackOn && (cnt % 9 == 8);
endmodule // tw_slave_model

// File: test/testbench.sv
// Self-checking bench of the two-wire controller in master mode.
// Assumes pull-ups on both lines and one acknowledging peripheral.
`timescale 1ns/1ps

module testbench;
   import two_wire_pkg::*;
   logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, portOwn, ackOn = 1, sdaLo;
   logic chipIdle = 0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0, datO;
   logic [15:0] q;
   pinDrv_t pins;
   wire logic scl = ~pins.sclOe;
   wire logic sda = ~pins.sdaOe & ~sdaLo;
   int num_errors = 0, checks = 0, cycles = 0;
   two_wire_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .ack_o(ack), .dat_o(datO), .chipIdle(chipIdle),
      .sclIn(scl), .sdaIn(sda), .pins(pins), .portOwn(portOwn));
   tw_slave_model peer_u (.scl(scl), .sda(sda), .ackOn(ackOn), .sdaLo(sdaLo));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic stop_test;
      if (num_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         stop_test;
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Single classic cycle; the next call's first edge gives the idle gap
   task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= {16'h0, d};
      do @(posedge ref_clk); while (ack !== 1'b1);
      q = datO[15:0];
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic waitBit(input logic [4:0] a, input int b);
      do wb(0, a, 16'h0); while (q[b] !== 1'b0);
   endtask
   task automatic testReset;
      wb(0, 5'h00, 16'h0);
      chk("ctl reset", 16'h1000, q);
      wb(1, 5'h1c, 16'hffff);
      wb(0, 5'h1c, 16'h0);
      chk("unmapped", 16'h0, q);
      wb(1, 5'h00, 16'h0);
      wb(0, 5'h00, 16'h0);
      chk("release set only", 16'h1000, q);
      chk("port off", 16'h0, {15'h0, portOwn});
   endtask
   task automatic testTx;
      wb(1, 5'h08, 16'h0002);
      wb(1, 5'h00, 16'h9001);
      waitBit(5'h00, 0);
      chk("port on", 16'h1, {15'h0, portOwn});
      chk("start held", 2'b00, {scl, sda});
      wb(1, 5'h14, 16'h00a0);
      wb(1, 5'h14, 16'h0055);
      wb(0, 5'h04, 16'h0);
      chk("collision", 16'h1, {15'h0, q[7]});
      waitBit(5'h04, 0);
      chk("acked", 16'h0, {15'h0, q[15]});
      wb(1, 5'h04, 16'h0080);
      wb(0, 5'h04, 16'h0);
      chk("collision clear", 16'h0, {15'h0, q[7]});
      ackOn = 0;
      wb(1, 5'h14, 16'h0033);
      waitBit(5'h04, 0);
      chk("nack", 16'h1, {15'h0, q[15]});
   endtask
   task automatic testRx;
      wb(1, 5'h00, 16'h9002);
      waitBit(5'h00, 1);
      chk("restart held", 2'b00, {scl, sda});
      wb(1, 5'h00, 16'h9008);
      waitBit(5'h00, 3);
      wb(0, 5'h18, 16'h0);
      chk("rx byte", 16'h00ff, q);
      wb(1, 5'h00, 16'h9030);
      waitBit(5'h00, 4);
      chk("ack go clear", 16'h9020, q);
   endtask
   task automatic testStop;
      chipIdle <= 1;
      wb(1, 5'h00, 16'hb004);
      repeat (20) @(posedge ref_clk);
      wb(0, 5'h00, 16'h0);
      chk("halted", 16'hb004, q);
      chipIdle <= 0;
      waitBit(5'h00, 2);
      chk("stop lines", 2'b11, {scl, sda});
      wb(1, 5'h00, 16'h0000);
      wb(0, 5'h00, 16'h0);
      chk("port off", 16'h0, {15'h0, portOwn});
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1;
      testReset;
      testTx;
      testRx;
      testStop;
      stop_test;
   end
endmodule // testbench
